/* File: logic/frs_cycle_timer.sv */
/*
  down counter that times one flash cycle and pulses done at the end.
  assumes load is a single-cycle pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none

module frs_cycle_timer
  import frs_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadVal,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load)
    begin
      cnt_d = loadVal;
    end
    else if (cnt_q != '0)
    begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;

endmodule // frs_cycle_timer

`default_nettype wire

/* File: logic/frs_flash_seq.sv */
/*
  flash row erase / program sequencer: control word, unlock key port,
  table page pointer, cpu stall and hardware-cleared start bit.
  assumes the cpu writes arrive as single-cycle strobes on ref_clk and
  the flash macro accepts a command pulse plus row address.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: erase and program act on 32-word rows
// RQ2: op 011000 with erase and flash_write_enable_flag: row erase
// RQ3: op 000100, erase clear, flash_write_enable_flag: row program
// RQ4: software sets row address before erase
// RQ5: keys 55h then AAh right before start
// RQ6: start bit begins cycle, cpu stalled throughout
// RQ7: start bit cleared by hardware at end
// RQ8: software fills 32-word buffer before program
// RQ9: software follows start with two nops
// RQ10: software blocks interrupts around unlock sequence
// RQ11: erase control word with flash_write_enable_flag is 4058h
// RQ12: no key or no flash_write_enable_flag: nothing starts
module frs_flash_seq
  import frs_pkg::*;
#(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT  = PROG_CYCLES
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ctrlWrEn,
  input  wire logic [CTRL_W-1:0] ctrlWrData,
  input  wire logic              keyWrEn,
  input  wire logic [7:0]        keyWrData,
  input  wire logic              pageWrEn,
  input  wire logic [PAGE_W-1:0] pageWrData,
  input  wire logic              tblWrEn,
  input  wire logic [15:0]       tblWrOffset,
  input  wire logic              otherWrEn,
  output logic [CTRL_W-1:0]      flashCtrlReg,
  output logic [PAGE_W-1:0]      tablePagePointer,
  output logic                   cpuStall,
  output frs_cmd_s               flashCmd,
  output logic                   cycleDone
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  frs_state_e        state_q, state_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [15:0]       offs_q, offs_d;
  logic [1:0]        keyStep_q, keyStep_d;
  frs_cmd_s          cmd_q, cmd_d;
  logic              load;
  logic [CNT_W-1:0]  loadVal;
  logic              tmrBusy;
  logic              tmrDone;
  logic              startReq;
  logic              opErase;
  logic              opProg;
  logic [OP_W-1:0]   opCode;
  logic [ADDR_W-1:0] rowBase;

  // one down counter serves both cycles; only the load value differs
  frs_cycle_timer #(
    .WIDTH (CNT_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (load),
    .loadVal (loadVal),
    .busy    (tmrBusy),
    .done    (tmrDone)
  );

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  // op field, low six bits of the written word
  assign opCode  = ctrlWrData[OP_LSB +: OP_W];
  // RQ2: row erase decode
  // RQ11: 4058h plus start is erase
  assign opErase = (opCode == OP_ROW_ERASE) && ctrlWrData[ERASE_BIT]
                   && ctrlWrData[FLASH_WRITE_ENABLE_FLAG_BIT];
  // RQ3: row program decode
  assign opProg  = (opCode == OP_ROW_PROG) && !ctrlWrData[ERASE_BIT]
                   && ctrlWrData[FLASH_WRITE_ENABLE_FLAG_BIT];
  // RQ5: start needs both keys
  assign startReq = ctrlWrEn && ctrlWrData[START_BIT] && (keyStep_q == 2'd2)
                    && (state_q == FRS_IDLE);

  // RQ1: row base, low bits cleared (two addresses per word)
  assign rowBase  = {page_q, offs_q} & ~ADDR_W'(ROW_WORDS * 2 - 1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_d   = state_q;
    ctrl_d    = ctrl_q;
    page_d    = page_q;
    offs_d    = offs_q;
    keyStep_d = keyStep_q;
    cmd_d     = '0;
    load      = 1'b0;
    loadVal   = '0;
    // RQ4: row address capture
    if (pageWrEn)
    begin
      page_d = pageWrData;
    end
    if (tblWrEn)
    begin
      offs_d = tblWrOffset;
    end
    // RQ5: key sequence tracking, any other write breaks it
    // a fresh 55h always restarts the count, even mid-sequence
    if (keyWrEn)
    begin
      if (keyWrData == KEY_FIRST)
      begin
        keyStep_d = 2'd1;
      end
      else if (keyWrData == KEY_SECOND && keyStep_q == 2'd1)
      begin
        keyStep_d = 2'd2;
      end
      else
      begin
        keyStep_d = 2'd0;
      end
    end
    else if (ctrlWrEn || otherWrEn || pageWrEn || tblWrEn)
    begin
      keyStep_d = 2'd0;
    end
    case (state_q)
      FRS_IDLE:
      begin
        if (ctrlWrEn)
        begin
          // RQ12: start bit stays clear unless unlocked
          ctrl_d = {1'b0, ctrlWrData[CTRL_W-2:0]};
          if (startReq && (opErase || opProg))
          begin
            ctrl_d[START_BIT] = 1'b1;
            load              = 1'b1;
            // RQ1: command covers one 32-word row
            cmd_d.valid       = 1'b1;
            cmd_d.erase       = opErase;
            cmd_d.rowAddr     = rowBase;
            if (opErase)
            begin
              loadVal = CNT_W'(ERASE_CNT);
              state_d = FRS_ERASE;
            end
            else
            begin
              loadVal = CNT_W'(PROG_CNT);
              state_d = FRS_PROG;
            end
          end
        end
      end
      FRS_ERASE, FRS_PROG:
      begin
        // control writes dropped here; the cpu is stalled anyway
        // RQ7: hardware clears start bit
        if (tmrDone)
        begin
          ctrl_d[START_BIT] = 1'b0;
          state_d           = FRS_IDLE;
        end
      end
      default:
      begin
        // unused code: back to idle, no half-begun cycle
        state_d = FRS_IDLE;
      end
    endcase
  end

  // all state resets together, so a cut cycle leaves nothing behind
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= FRS_IDLE;
      ctrl_q    <= CTRL_RESET;
      page_q    <= '0;
      offs_q    <= '0;
      keyStep_q <= 2'd0;
      cmd_q     <= '0;
    end
    else
    begin
      state_q   <= state_d;
      ctrl_q    <= ctrl_d;
      page_q    <= page_d;
      offs_q    <= offs_d;
      keyStep_q <= keyStep_d;
      cmd_q     <= cmd_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign flashCtrlReg     = ctrl_q;
  assign tablePagePointer = page_q;
  assign flashCmd         = cmd_q;
  assign cycleDone        = tmrDone;
  // cpu resumes only once the start bit already reads clear
  // RQ6: stall cpu for whole cycle
  assign cpuStall         = (state_q != FRS_IDLE) || tmrBusy;

endmodule // frs_flash_seq

`default_nettype wire

/* File: logic/frs_pkg.sv */
/*
  package for the flash row sequencer: control word layout, op codes,
  unlock keys, timing counts and the carrier structs.
  assumes a 40 MHz system clock.
*/
package frs_pkg;

  // ----------------------------------------
  // control word layout
  // ----------------------------------------
  localparam int unsigned CTRL_W      = 16;
  localparam int unsigned START_BIT   = 15;
  localparam int unsigned FLASH_WRITE_ENABLE_FLAG_BIT    = 14;
  localparam int unsigned ERASE_BIT   = 6;
  localparam int unsigned OP_LSB      = 0;
  localparam int unsigned OP_W        = 6;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [5:0]  OP_ROW_ERASE = 6'h18;
  localparam logic [5:0]  OP_ROW_PROG  = 6'h04;
  localparam logic [15:0] CTRL_ERASE_WORD = 16'h4058;

  // ----------------------------------------
  // unlock keys and row geometry
  // ----------------------------------------
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'hAA;
  localparam int unsigned ROW_WORDS   = 32;
  localparam int unsigned INSTR_W     = 24;
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned PAGE_W      = 8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned ERASE_TIME_US   = 2000;
  localparam int unsigned PROG_TIME_US    = 2000;
  localparam int unsigned ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 20;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FRS_IDLE  = 2'b00,
    FRS_ERASE = 2'b01,
    FRS_PROG  = 2'b10
  } frs_state_e;

  typedef struct packed {
    logic              valid;
    logic              erase;
    logic [ADDR_W-1:0] rowAddr;
  } frs_cmd_s;

endpackage

/* File: sim/frs_cpu_model.sv */
/* cpu side model: runs the unlock and start sequence by task.
   assumes the sequencer samples strobes on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module frs_cpu_model
(
  input  wire logic   ref_clk,
  output logic        ctrlWrEn,
  output logic [15:0] ctrlWrData,
  output logic        keyWrEn,
  output logic [7:0]  keyWrData,
  output logic        pageWrEn,
  output logic [7:0]  pageWrData,
  output logic        tblWrEn,
  output logic [15:0] tblWrOffset,
  output logic        otherWrEn
);
  initial {ctrlWrEn, keyWrEn, pageWrEn, tblWrEn, otherWrEn, ctrlWrData, tblWrOffset} = '0;
  initial {keyWrData, pageWrData} = '0;
  // one write a cycle; sel 5 releases all strobes, and run passes it flipped data so stale values never match
  task automatic put(input logic [2:0] sel, input logic [15:0] d);
    @(posedge ref_clk) #1;
    {ctrlWrEn, keyWrEn, pageWrEn, tblWrEn, otherWrEn} = 5'h10 >> sel;
    ctrlWrData = d;
    keyWrData = d[7:0];
    pageWrData = d[7:0];
    tblWrOffset = d;
  endtask
  task automatic run(input logic [15:0] w, input logic [7:0] k2, input logic brk);
    put(3'h2, 16'h0012);
    put(3'h3, 16'h3456);
    put(3'h0, w & 16'h7FFF);
    put(3'h1, 16'h0055);
    if (brk)
      put(3'h4, 16'h0000);
    put(3'h1, {8'h00, k2});
    put(3'h0, w);
    put(3'h5, ~w);
  endtask
endmodule // frs_cpu_model
`default_nettype wire

/* File: sim/frs_flash_seq_asserts.sv */
/* port checker for frs_flash_seq.
   assumes one clock and the small sim counts. */
`timescale 1ns/1ps
`default_nettype none
module frs_flash_seq_asserts
  import frs_pkg::*;
#(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT  = PROG_CYCLES
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        ctrlWrEn,
  input wire logic [15:0] ctrlWrData,
  input wire logic        keyWrEn,
  input wire logic [7:0]  keyWrData,
  input wire logic        cpuStall,
  input wire logic [15:0] flashCtrlReg,
  input wire frs_cmd_s    flashCmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----
  // stall length
  // ----
  logic [CNT_W-1:0] stallCnt_q;
  logic [CNT_W-1:0] stallCnt_d;
  always_comb stallCnt_d = cpuStall ? stallCnt_q + 1'b1 : '0;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      stallCnt_q <= '0;
    else
      stallCnt_q <= stallCnt_d;
  // start attempt without the second key just before
  sequence s_bareStart;
    ctrlWrEn && ctrlWrData[15] && !cpuStall
      && !($past(keyWrEn) && $past(keyWrData) == KEY_SECOND);
  endsequence
  property p_startAns; $rose(cpuStall) |-> flashCmd.valid && flashCtrlReg[15]; endproperty
  a_startAns: assert property (p_startAns) else $error("stall without command");
  property p_hold; $rose(cpuStall) |=> cpuStall[*8]; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped early");
  // stall also spans the cycle that registers done
  property p_clearHw;
    $fell(cpuStall) |-> !flashCtrlReg[15]
      && (stallCnt_q == ERASE_CNT + 1 || stallCnt_q == PROG_CNT + 1);
  endproperty
  a_clearHw: assert property (p_clearHw) else $error("bad cycle end");
  property p_bound;
    stallCnt_q <= ((ERASE_CNT > PROG_CNT) ? ERASE_CNT : PROG_CNT) + 1;
  endproperty
  a_bound: assert property (p_bound) else $error("stall too long");
  property p_noWren; ctrlWrEn && !ctrlWrData[14] && !cpuStall |=> !cpuStall; endproperty
  a_noWren: assert property (p_noWren) else $error("start without flash_write_enable_flag");
  property p_noKey; s_bareStart |=> !cpuStall; endproperty
  a_noKey: assert property (p_noKey) else $error("start without keys");
  property p_decode;
    flashCmd.valid |-> (flashCmd.erase ? flashCtrlReg[14:0] == 15'h4058
      : flashCtrlReg[6:0] == 7'h04 && flashCtrlReg[14]);
  endproperty
  a_decode: assert property (p_decode) else $error("bad op decode");
  property p_row; flashCmd.valid |-> flashCmd.rowAddr[5:0] == 6'h00; endproperty
  a_row: assert property (p_row) else $error("row not aligned");
endmodule // frs_flash_seq_asserts
bind frs_flash_seq frs_flash_seq_asserts #(.ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) i_asserts
(
  .ref_clk, .rst, .ctrlWrEn, .ctrlWrData, .keyWrEn, .keyWrData,
  .cpuStall, .flashCtrlReg, .flashCmd
);
`default_nettype wire

/* File: sim/frs_flash_seq_tb_top.sv */
/* self-checking bench for the flash row sequencer.
   assumes frs_cpu_model drives every write strobe. */
`timescale 1ns/1ps
`default_nettype none
module frs_flash_seq_tb_top
  import frs_pkg::*;
;
  localparam int unsigned N = 10;
  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  key2;
    logic        brk;
    logic        go;
  } frs_row_s;
  frs_row_s rows [6] = '{'{16'hC058, 8'hAA, 1'b0, 1'b1}, '{16'hC004, 8'hAA, 1'b0, 1'b1},
    '{16'hC058, 8'h00, 1'b0, 1'b0}, '{16'h8058, 8'hAA, 1'b0, 1'b0},
    '{16'hC058, 8'hAA, 1'b1, 1'b0}, '{16'hC018, 8'hAA, 1'b0, 1'b0}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ctrlWrEn, keyWrEn, pageWrEn, tblWrEn, otherWrEn, cpuStall, cycleDone;
  logic [15:0] ctrlWrData, tblWrOffset, flashCtrlReg;
  logic [7:0] keyWrData, pageWrData, tablePagePointer;
  frs_cmd_s flashCmd;
  int failures = 0;
  int numChecks = 0;
  int n;
  logic [7:0] dn, vn;
  always #12.5 ref_clk = ~ref_clk;
  frs_cpu_model i_cpu (.ref_clk, .ctrlWrEn, .ctrlWrData, .keyWrEn, .keyWrData,
    .pageWrEn, .pageWrData, .tblWrEn, .tblWrOffset, .otherWrEn);
  frs_flash_seq #(.ERASE_CNT(N), .PROG_CNT(N)) i_dut (.ref_clk, .rst, .ctrlWrEn,
    .ctrlWrData, .keyWrEn, .keyWrData, .pageWrEn, .pageWrData, .tblWrEn, .tblWrOffset,
    .otherWrEn, .flashCtrlReg, .tablePagePointer, .cpuStall, .flashCmd, .cycleDone);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk({cycleDone, flashCmd.valid, cpuStall, flashCtrlReg, tablePagePointer}, '0);
    foreach (rows[i])
    begin
      i_cpu.run(rows[i].word, rows[i].key2, rows[i].brk);
      chk({cpuStall, flashCmd.valid}, {2{rows[i].go}});
      chk(tablePagePointer, 8'h12);
      if (rows[i].go)
        chk({flashCmd.erase, flashCmd.rowAddr}, {rows[i].word[6], 24'h123440});
      n = 0;
      dn = 8'h00;
      vn = 8'h00;
      while (cpuStall && n < 40)
      begin
        @(posedge ref_clk) #1;
        n++;
        dn = dn + cycleDone;
        vn = vn + flashCmd.valid;
      end
      // stall spans the load count plus the cycle that registers done
      chk(n, rows[i].go ? N + 1 : 0);
      chk({dn, vn}, {7'h00, rows[i].go, 8'h00});
      chk(flashCtrlReg[15], 1'b0);
      chk(flashCtrlReg, rows[i].word & 16'h7FFF);
      if (n >= 40)
        summarize();
    end
    // control write in mid cycle is dropped, then reset cuts the cycle
    i_cpu.run(16'hC058, 8'hAA, 1'b0);
    i_cpu.put(3'h0, 16'h0000);
    i_cpu.put(3'h5, 16'hFFFF);
    chk({cpuStall, flashCtrlReg}, 17'h1C058);
    rst = 1'b1;
    #1;
    chk({cpuStall, flashCtrlReg}, '0);
    @(posedge ref_clk) #1;
    rst = 1'b0;
    i_cpu.run(16'hC004, 8'hAA, 1'b0);
    chk({cpuStall, flashCmd.valid, flashCmd.erase}, 3'h6);
    summarize();
  end
endmodule // frs_flash_seq_tb_top
`default_nettype wire
